// ===== shhcr_regs.sv
// Host control register bank of the sensor hub, reached over the two-wire host link
//
// Overview of operation
// - Self-test requested on leaving standby when bit set
// - Host asleep: only wakeup events and data left after abort raise interrupt
// - Coordinate bit selects north-east-down frame
// - Wakeup disable drops interrupt, blocks wakeup interrupts
// - Count update refreshes remaining bytes from FIFO
// - Count update never lengthens a running transfer
// - Abort discards all pending transfer data
// - Abort drops interrupt and zeroes remaining count
// - Data left after abort requests a new transfer
// - Standby: algorithm pauses, then sensors power down
// - Leaving standby restarts sensors, resumes algorithm
// - First general area host writable, processor readable
// - Eight-byte parameter write buffer at 0x5c-0x63
// - Sensor configuration parameter fills eight bytes
// - Request register: direction bit 7, number bits 6-0
// - New request clears acknowledge to zero
// - Second general area host writable, processor readable
// - Acknowledge equals request, or 0x80 on error
// - Page select: size zero or oversize means maximum
// - Remaining count changes only before interrupt or update; also zeroed on abort, decremented per byte taken
`timescale 1ns/1ps
module shhcr_regs (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe,
  output logic                        host_irq,
  output shhcr_pkg::shhcr_ctrl_t      ctrl,
  output logic [47:0]                 gp_area_a,
  output logic [55:0]                 gp_area_b,
  output shhcr_pkg::shhcr_param_t     param,
  input  wire logic                   ack_load,
  input  wire logic [7:0]             ack_value,
  input  wire logic                   wake_event,
  input  wire logic                   nonwake_event,
  input  wire logic [15:0]            fifo_fill,
  input  wire logic                   fifo_byte_taken,
  output logic                        fifo_discard,
  input  wire logic                   algo_pause_ready,
  output logic                        algo_pause_req,
  output logic                        sensors_off,
  output logic                        sensors_restart,
  output logic                        self_test_start
);

  shhcr_pkg::shhcr_i2c_t i2c_st_r, after_ack_r;
  shhcr_pkg::shhcr_sb_t  sb_st_r;
  logic        scl_q_r, sda_q_r, nack_r, drive_low_r, irq_r, abort_follow_r;
  logic        req_pulse_r, discard_r, scl_rise, scl_fall, start_cond, stop_cond;
  logic        wr_stb, ctl_wr, abort_rise, update_rise, irq_qual, irq_drop;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r, ptr_r, ctrl_r, page_sel_r, ack_r, wr_data, rd_data;
  logic [7:0]  area_r [22];
  logic [15:0] rem_r, rem_nxt;

  // Link sampling and bus condition decode
  assign scl_rise   = scl_i & ~scl_q_r;
  assign scl_fall   = ~scl_i & scl_q_r;
  assign start_cond = scl_i & scl_q_r & sda_q_r & ~sda_i;
  assign stop_cond  = scl_i & scl_q_r & ~sda_q_r & sda_i;
  assign wr_stb     = clk_en & (i2c_st_r == shhcr_pkg::I_WR) & scl_fall & (bit_cnt_r == 4'h8);
  assign wr_data    = shift_r;
  assign ctl_wr     = wr_stb & (ptr_r == shhcr_pkg::OFS_HOST_CTL);
  assign sda_o      = 1'b0;
  assign sda_oe     = drive_low_r;
  // Line history, idle high so no false edge after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {scl_q_r, sda_q_r} <= 2'b11;
    end else if (clk_en) begin
      {scl_q_r, sda_q_r} <= {scl_i, sda_i};
    end
  end

  // Read data mux, unmapped offsets read zero
  always_comb begin
    if (ptr_r >= shhcr_pkg::OFS_GPA_LO && ptr_r <= shhcr_pkg::OFS_GPB_HI) begin
      rd_data = area_r[5'(ptr_r - shhcr_pkg::OFS_GPA_LO)];
    end else begin
      case (ptr_r)
        shhcr_pkg::OFS_REM_LO:   rd_data = rem_r[7:0];
        shhcr_pkg::OFS_REM_HI:   rd_data = rem_r[15:8];
        shhcr_pkg::OFS_PAR_ACK:  rd_data = ack_r;
        shhcr_pkg::OFS_PAGE_SEL: rd_data = page_sel_r;
        shhcr_pkg::OFS_HOST_CTL: rd_data = ctrl_r;
        default:                 rd_data = 8'h00;
      endcase
    end
  end

  // Two-wire target: address, register pointer, write and read bytes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      i2c_st_r    <= shhcr_pkg::I_IDLE;
      after_ack_r <= shhcr_pkg::I_IDLE;
      shift_r     <= 8'h00;
      bit_cnt_r   <= 4'h0;
      ptr_r       <= 8'h00;
      nack_r      <= 1'b0;
      drive_low_r <= 1'b0;
    end else if (clk_en) begin
      if (start_cond) begin
        i2c_st_r    <= shhcr_pkg::I_ADDR;
        bit_cnt_r   <= 4'h0;
        drive_low_r <= 1'b0;
      end else if (stop_cond) begin
        i2c_st_r    <= shhcr_pkg::I_IDLE;
        drive_low_r <= 1'b0;
      end else begin
        case (i2c_st_r)
          shhcr_pkg::I_ADDR, shhcr_pkg::I_REG, shhcr_pkg::I_WR: begin
            if (scl_rise && bit_cnt_r != 4'h8) begin
              shift_r   <= {shift_r[6:0], sda_i};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              drive_low_r <= 1'b1;
              i2c_st_r    <= shhcr_pkg::I_ACK;
              after_ack_r <= shhcr_pkg::I_WR;
              if (i2c_st_r == shhcr_pkg::I_ADDR) begin
                after_ack_r <= shift_r[0] ? shhcr_pkg::I_RD : shhcr_pkg::I_REG;
                if (shift_r[7:1] != shhcr_pkg::DEV_ADDR) begin
                  drive_low_r <= 1'b0;
                  i2c_st_r    <= shhcr_pkg::I_IDLE;
                end
              end else if (i2c_st_r == shhcr_pkg::I_REG) begin
                ptr_r <= shift_r;
              end else begin
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          shhcr_pkg::I_ACK: begin
            if (scl_fall) begin
              bit_cnt_r   <= 4'h0;
              i2c_st_r    <= after_ack_r;
              drive_low_r <= 1'b0;
              if (after_ack_r == shhcr_pkg::I_RD) begin
                shift_r     <= rd_data;
                ptr_r       <= ptr_r + 8'h01;
                drive_low_r <= ~rd_data[7];
              end
            end
          end
          shhcr_pkg::I_RD: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h7) begin
                drive_low_r <= 1'b0;
                i2c_st_r    <= shhcr_pkg::I_RACK;
              end else begin
                shift_r     <= {shift_r[6:0], 1'b0};
                bit_cnt_r   <= bit_cnt_r + 4'h1;
                drive_low_r <= ~shift_r[6];
              end
            end
          end
          shhcr_pkg::I_RACK: begin
            if (scl_rise) begin
              nack_r <= sda_i;
            end else if (scl_fall) begin
              if (nack_r) begin
                i2c_st_r <= shhcr_pkg::I_IDLE;
              end else begin
                shift_r     <= rd_data;
                ptr_r       <= ptr_r + 8'h01;
                bit_cnt_r   <= 4'h0;
                drive_low_r <= ~rd_data[7];
                i2c_st_r    <= shhcr_pkg::I_RD;
              end
            end
          end
          default: begin
            drive_low_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // General areas, write buffer and request register, one byte per entry
  for (genvar i = 0; i < 22; i++) begin : g_area
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        area_r[i] <= shhcr_pkg::RST_BYTE;
      end else if (wr_stb && ptr_r == shhcr_pkg::OFS_GPA_LO + 8'(i)) begin
        area_r[i] <= wr_data;
      end
    end
  end

  // Processor-side views of the host written areas
  assign gp_area_a = {area_r[5], area_r[4], area_r[3], area_r[2], area_r[1], area_r[0]};
  assign gp_area_b = {area_r[21], area_r[20], area_r[19], area_r[18], area_r[17],
                      area_r[16], area_r[15]};
  assign param.wr_data = {area_r[13], area_r[12], area_r[11], area_r[10], area_r[9],
                          area_r[8], area_r[7], area_r[6]};
  assign param.write_dir = area_r[14][shhcr_pkg::BIT_PAR_DIR];
  assign param.number    = area_r[14][6:0];
  assign param.strobe    = req_pulse_r;
  assign param.page      = page_sel_r[3:0];
  assign param.rd_size   = (page_sel_r[7:4] == 4'h0) ? shhcr_pkg::PAR_RD_MAX
                           : {1'b0, page_sel_r[7:4]};
  assign param.wr_size   = (page_sel_r[7:4] == 4'h0 || page_sel_r[7:4] > 4'h8)
                           ? shhcr_pkg::PAR_WR_MAX : {1'b0, page_sel_r[7:4]};

  // Page select, request strobe and acknowledge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      page_sel_r  <= shhcr_pkg::RST_BYTE;
      ack_r       <= shhcr_pkg::PAR_ACK_CLEAR;
      req_pulse_r <= 1'b0;
    end else if (clk_en) begin
      req_pulse_r <= wr_stb && ptr_r == shhcr_pkg::OFS_PAR_REQ;
      if (wr_stb && ptr_r == shhcr_pkg::OFS_PAGE_SEL) begin
        page_sel_r <= wr_data;
      end
      if (ack_load) begin
        ack_r <= ack_value;
      end else if (wr_stb && ptr_r == shhcr_pkg::OFS_PAR_REQ) begin
        ack_r <= shhcr_pkg::PAR_ACK_CLEAR;
      end
    end
  end

  // Host control register and its write edges
  assign abort_rise  = ctl_wr & wr_data[shhcr_pkg::BIT_ABORT] & ~ctrl_r[shhcr_pkg::BIT_ABORT];
  assign update_rise = ctl_wr & wr_data[shhcr_pkg::BIT_UPD_CNT]
                       & ~ctrl_r[shhcr_pkg::BIT_UPD_CNT];
  assign ctrl        = ctrl_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= shhcr_pkg::RST_HOST_CTL;
    end else if (ctl_wr) begin
      ctrl_r <= wr_data;
    end
  end

  // Interrupt qualification and drop conditions
  assign irq_qual = (wake_event & ~ctrl_r[shhcr_pkg::BIT_WAKE_DIS])
                  | (nonwake_event & ~ctrl_r[shhcr_pkg::BIT_NW_DIS]
                     & ~ctrl_r[shhcr_pkg::BIT_ASLEEP])
                  | (abort_follow_r & ~abort_rise & fifo_fill != 16'h0000);
  assign irq_drop = abort_rise
                  | (ctl_wr & wr_data[shhcr_pkg::BIT_WAKE_DIS])
                  | (ctl_wr & wr_data[shhcr_pkg::BIT_NW_DIS])
                  | (fifo_byte_taken & rem_r == 16'h0001);
  assign host_irq = irq_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_r          <= 1'b0;
      abort_follow_r <= 1'b0;
      discard_r      <= 1'b0;
    end else if (clk_en) begin
      discard_r      <= abort_rise;
      abort_follow_r <= abort_rise;
      if (irq_qual && !abort_rise) begin
        irq_r <= 1'b1;
      end else if (irq_drop) begin
        irq_r <= 1'b0;
      end
    end
  end
  assign fifo_discard = discard_r;
  // Remaining byte count
  always_comb begin
    rem_nxt = rem_r;
    if (abort_rise) begin
      rem_nxt = 16'h0000;
    end else if (irq_qual) begin
      rem_nxt = fifo_fill;
    end else if (update_rise) begin
      rem_nxt = (irq_r && fifo_fill > rem_r) ? rem_r : fifo_fill;
    end else if (fifo_byte_taken && rem_r != 16'h0000) begin
      rem_nxt = rem_r - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rem_r <= shhcr_pkg::RST_REM;
    end else if (clk_en) begin
      rem_r <= rem_nxt;
    end
  end
  // Standby sequencing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sb_st_r <= shhcr_pkg::SB_RUN;
    end else if (clk_en) begin
      case (sb_st_r)
        shhcr_pkg::SB_RUN: begin
          if (ctrl_r[shhcr_pkg::BIT_STANDBY]) begin
            sb_st_r <= shhcr_pkg::SB_PREP;
          end
        end
        shhcr_pkg::SB_PREP: begin
          if (algo_pause_ready) begin
            sb_st_r <= shhcr_pkg::SB_OFF;
          end else if (!ctrl_r[shhcr_pkg::BIT_STANDBY]) begin
            sb_st_r <= shhcr_pkg::SB_RESUME;
          end
        end
        shhcr_pkg::SB_OFF: begin
          if (!ctrl_r[shhcr_pkg::BIT_STANDBY]) begin
            sb_st_r <= shhcr_pkg::SB_RESUME;
          end
        end
        default: begin
          sb_st_r <= shhcr_pkg::SB_RUN;
        end
      endcase
    end
  end

  assign algo_pause_req  = (sb_st_r == shhcr_pkg::SB_PREP);
  assign sensors_off     = (sb_st_r == shhcr_pkg::SB_OFF);
  assign sensors_restart = (sb_st_r == shhcr_pkg::SB_RESUME);
  assign self_test_start = (sb_st_r == shhcr_pkg::SB_RESUME)
                           & ctrl_r[shhcr_pkg::BIT_SELFTEST];

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_abort_clears: assert property (clk_en && abort_rise |=> !irq_r && rem_r == 16'h0000)
    else $error("abort did not clear interrupt and count");
  chk_abort_discard: assert property (clk_en && abort_rise |=> fifo_discard)
    else $error("abort did not pulse discard");
  chk_asleep_block: assert property (clk_en && !irq_r && nonwake_event && !wake_event
      && ctrl_r[shhcr_pkg::BIT_ASLEEP] && !abort_follow_r |=> !irq_r)
    else $error("non-wakeup event raised interrupt while host asleep");
  chk_wake_dis_drop: assert property (clk_en && ctl_wr && !wake_event && !nonwake_event
      && wr_data[shhcr_pkg::BIT_WAKE_DIS] && !abort_follow_r |=> !irq_r)
    else $error("wakeup disable did not drop interrupt");
  chk_nw_dis_block: assert property (clk_en && !irq_r && nonwake_event && !wake_event
      && ctrl_r[shhcr_pkg::BIT_NW_DIS] && !abort_follow_r |=> !irq_r)
    else $error("non-wakeup disable did not block interrupt");
  chk_update_bound: assert property (clk_en && update_rise && irq_r && !irq_qual
      && !abort_rise |=> rem_r <= $past(rem_r))
    else $error("count update lengthened transfer");
  chk_count_stable: assert property (clk_en && !irq_qual && !update_rise && !abort_rise
      && !fifo_byte_taken |=> $stable(rem_r))
    else $error("remaining count changed without cause");
  chk_req_ack_clear: assert property (clk_en && wr_stb
      && ptr_r == shhcr_pkg::OFS_PAR_REQ && !ack_load |=> ack_r == 8'h00 && req_pulse_r)
    else $error("request did not clear acknowledge");
  chk_standby_seq: assert property (clk_en && sb_st_r == shhcr_pkg::SB_PREP
      && algo_pause_ready |=> sensors_off)
    else $error("sensors not powered down after pause");
  chk_resume_pulse: assert property (clk_en && sensors_restart |=> !sensors_restart)
    else $error("restart pulse longer than one cycle");
  chk_selftest: assert property (clk_en && sensors_off && !ctl_wr
      && ctrl_r[shhcr_pkg::BIT_SELFTEST] && !ctrl_r[shhcr_pkg::BIT_STANDBY] |=> self_test_start)
    else $error("self-test not started on standby exit");
  cov_abort: cover property (clk_en && abort_rise ##[1:4] irq_r);
  cov_standby: cover property (sensors_off ##[1:50] sensors_restart);
  cov_write_byte: cover property (wr_stb && ptr_r == shhcr_pkg::OFS_PWB_LO);
endmodule

// ===== shhcr_pkg.sv
// Package: register map, field positions and types of the host control register bank
package shhcr_pkg;

  // Target address on the two-wire host link; value is a plain default
  localparam logic [6:0] DEV_ADDR = 7'h28;

  // Register offsets
  localparam logic [7:0] OFS_REM_LO   = 8'h38;
  localparam logic [7:0] OFS_REM_HI   = 8'h39;
  localparam logic [7:0] OFS_PAR_ACK  = 8'h3a;
  localparam logic [7:0] OFS_PAGE_SEL = 8'h54;
  localparam logic [7:0] OFS_HOST_CTL = 8'h55;
  localparam logic [7:0] OFS_GPA_LO   = 8'h56;
  localparam logic [7:0] OFS_GPA_HI   = 8'h5b;
  localparam logic [7:0] OFS_PWB_LO   = 8'h5c;
  localparam logic [7:0] OFS_PWB_HI   = 8'h63;
  localparam logic [7:0] OFS_PAR_REQ  = 8'h64;
  localparam logic [7:0] OFS_GPB_LO   = 8'h65;
  localparam logic [7:0] OFS_GPB_HI   = 8'h6b;

  // Host control bit positions
  localparam int BIT_STANDBY  = 0;
  localparam int BIT_ABORT    = 1;
  localparam int BIT_UPD_CNT  = 2;
  localparam int BIT_WAKE_DIS = 3;
  localparam int BIT_NED      = 4;
  localparam int BIT_ASLEEP   = 5;
  localparam int BIT_SELFTEST = 6;
  localparam int BIT_NW_DIS   = 7;

  // Parameter request fields
  localparam int BIT_PAR_DIR = 7;

  // Reset values
  localparam logic [7:0]  RST_HOST_CTL = 8'h00;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_REM      = 16'h0000;

  // Acknowledge codes and transfer size limits
  localparam logic [7:0] PAR_ACK_CLEAR = 8'h00;
  localparam logic [7:0] PAR_ACK_ERROR = 8'h80;
  localparam logic [4:0] PAR_RD_MAX    = 5'h10;
  localparam logic [4:0] PAR_WR_MAX    = 5'h08;

  // Fields of the host control register
  typedef struct packed {
    logic nw_fifo_irq_dis;
    logic self_test_req;
    logic host_processor_asleep;
    logic north_east_down_select;
    logic wake_fifo_irq_dis;
    logic update_count;
    logic abort_transfer;
    logic standby_req;
  } shhcr_ctrl_t;

  // Parameter mailbox towards the internal processor
  typedef struct packed {
    logic        strobe;
    logic        write_dir;
    logic [6:0]  number;
    logic [3:0]  page;
    logic [4:0]  rd_size;
    logic [4:0]  wr_size;
    logic [63:0] wr_data;
  } shhcr_param_t;

  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_REG, I_WR, I_ACK, I_RD, I_RACK} shhcr_i2c_t;
  typedef enum logic [1:0] {SB_RUN, SB_PREP, SB_OFF, SB_RESUME} shhcr_sb_t;

endpackage

// ===== shhcr_host_model.sv
// Two-wire host master model driving the register link of the bank
`timescale 1ns/1ps
module shhcr_host_model (
  input  wire logic ref_clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda
);
  // Released link idles high on both lines
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // A third of a link bit, lines change at the falling edge
  task automatic tick();
    repeat (2) @(negedge ref_clk);
  endtask

  // Start or repeated start, data falls while clock high
  task automatic start();
    sda = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda = 1'b0;
    tick();
    scl = 1'b0;
    tick();
  endtask

  // Stop, data rises while clock high
  task automatic stop();
    sda = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda = 1'b1;
    tick();
  endtask

  // One bit; a released line reads back the wire level
  task automatic bit_io(input logic b, output logic r);
    sda = b;
    tick();
    scl = 1'b1;
    tick();
    r = sda_w;
    scl = 1'b0;
    tick();
  endtask

  // Byte out, most significant bit first, returns the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in, the last one answered with a refusal
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ===== shhcr_regs_tb_top.sv
// Self-checking bench for the host control register bank
`timescale 1ns/1ps
module shhcr_regs_tb_top;
  logic                    ref_clk, reset_n, scl, sda_h, sda_w, sda_o, sda_oe, host_irq;
  shhcr_pkg::shhcr_ctrl_t  ctrl;
  shhcr_pkg::shhcr_param_t param;
  logic [47:0]             gp_a;
  logic [55:0]             gp_b;
  logic [3:0]              ev;
  logic [7:0]              ack_value;
  logic [15:0]             fifo_fill;
  logic                    fifo_discard, algo_pause_ready, algo_pause_req, sensors_off;
  logic                    sensors_restart, self_test_start;
  int                      n_errors = 0, checked = 0, n_stb = 0, n_disc = 0, n_rst = 0, n_st = 0;

  // Open-drain data wire with pull-up
  assign sda_w = sda_h & ~sda_oe;

  shhcr_host_model host (.ref_clk, .sda_w, .scl, .sda(sda_h));

  shhcr_regs dut (
    .ref_clk, .reset_n, .clk_en(1'b1), .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe,
    .host_irq, .ctrl, .gp_area_a(gp_a), .gp_area_b(gp_b), .param, .ack_load(ev[3]),
    .ack_value, .wake_event(ev[0]), .nonwake_event(ev[1]), .fifo_fill,
    .fifo_byte_taken(ev[2]), .fifo_discard, .algo_pause_ready, .algo_pause_req,
    .sensors_off, .sensors_restart, .self_test_start
  );

  // Clock of 10 ns
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Count one-cycle pulses
  always @(posedge ref_clk) begin
    if (param.strobe === 1'b1) n_stb++;
    if (fifo_discard === 1'b1) n_disc++;
    if (sensors_restart === 1'b1) n_rst++;
    if (self_test_start === 1'b1) n_st++;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Register write: pointer then data bytes
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    logic ack;
    logic all;
    host.start();
    host.wbyte({shhcr_pkg::DEV_ADDR, 1'b0}, ack);
    all = ack;
    host.wbyte(a, ack);
    all = all & ack;
    foreach (d[i]) begin
      host.wbyte(d[i], ack);
      all = all & ack;
    end
    host.stop();
    chk(all, 1'b1, "write ack");
  endtask

  // Register read of n bytes, first byte lowest, compared
  task automatic rchk(input logic [7:0] a, input int n, input logic [63:0] exp);
    logic ack;
    logic [7:0] b;
    logic [63:0] v;
    v = '0;
    host.start();
    host.wbyte({shhcr_pkg::DEV_ADDR, 1'b0}, ack);
    host.wbyte(a, ack);
    host.start();
    host.wbyte({shhcr_pkg::DEV_ADDR, 1'b1}, ack);
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, b);
      v[8*i +: 8] = b;
    end
    host.stop();
    chk(ack, 1'b1, "read ack");
    chk(v, exp, "read");
  endtask

  // Single-cycle event pulse
  task automatic pulse(input int k);
    @(negedge ref_clk);
    ev[k] = 1'b1;
    @(negedge ref_clk);
    ev = '0;
    @(negedge ref_clk);
  endtask

  task automatic t_reset();
    logic ack;
    chk({ctrl, gp_a, host_irq, sda_oe, sda_o}, '0, "reset state");
    rchk(8'h55, 1, 8'h00);
    rchk(8'h20, 1, 8'h00);
    host.start();
    host.wbyte({shhcr_pkg::DEV_ADDR ^ 7'h01, 1'b0}, ack);
    host.stop();
    chk(ack, 1'b0, "foreign address");
    $display("t_reset done");
  endtask

  task automatic t_gp();
    wr(8'h56, '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16});
    chk(gp_a, 48'h161514131211, "area a");
    wr(8'h65, '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27});
    chk(gp_b, 56'h27262524232221, "area b");
    rchk(8'h5b, 1, 8'h16);
    wr(8'h38, '{8'h5a});
    rchk(8'h38, 1, 8'h00);
    $display("t_gp done");
  endtask

  task automatic t_param();
    int b;
    ack_value = 8'h33;
    pulse(3);
    wr(8'h54, '{8'h03});
    wr(8'h5c, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
    b = n_stb;
    wr(8'h64, '{8'h85});
    chk(n_stb - b, 1, "request strobe");
    chk({param.write_dir, param.number, param.page}, {1'b1, 7'h05, 4'h3}, "request");
    chk({param.rd_size, param.wr_size}, {5'h10, 5'h08}, "size zero");
    chk(param.wr_data, 64'h0807060504030201, "write data");
    rchk(8'h3a, 1, 8'h00);
    ack_value = 8'h80;
    pulse(3);
    rchk(8'h3a, 1, 8'h80);
    wr(8'h54, '{8'hf2});
    wr(8'h64, '{8'h07});
    chk({param.write_dir, param.number, param.page}, {1'b0, 7'h07, 4'h2}, "read req");
    chk({param.rd_size, param.wr_size}, {5'h0f, 5'h08}, "size big");
    ack_value = 8'h07;
    pulse(3);
    rchk(8'h3a, 1, 8'h07);
    $display("t_param done");
  endtask

  task automatic t_irq();
    fifo_fill = 16'h0005;
    pulse(0);
    chk(host_irq, 1'b1, "wake irq");
    rchk(8'h38, 2, 16'h0005);
    repeat (5) pulse(2);
    chk(host_irq, 1'b0, "drained");
    wr(8'h55, '{8'h20});
    pulse(1);
    chk(host_irq, 1'b0, "asleep other");
    pulse(0);
    chk(host_irq, 1'b1, "asleep wake");
    wr(8'h55, '{8'h28});
    chk(host_irq, 1'b0, "wake disable");
    pulse(0);
    chk(host_irq, 1'b0, "wake blocked");
    wr(8'h55, '{8'h80});
    pulse(1);
    chk(host_irq, 1'b0, "other blocked");
    pulse(0);
    chk(host_irq, 1'b1, "wake passes");
    wr(8'h55, '{8'h80});
    chk(host_irq, 1'b0, "other disable");
    wr(8'h55, '{8'h00});
    $display("t_irq done");
  endtask

  task automatic t_abort();
    int b;
    fifo_fill = 16'h000a;
    pulse(0);
    b = n_disc;
    wr(8'h55, '{8'h02});
    chk(n_disc - b, 1, "discard");
    chk(host_irq, 1'b1, "new request");
    rchk(8'h38, 2, 16'h000a);
    repeat (20) @(negedge ref_clk);
    wr(8'h55, '{8'h00});
    fifo_fill = 16'h0000;
    wr(8'h55, '{8'h02});
    chk(host_irq, 1'b0, "abort drop");
    rchk(8'h38, 2, 16'h0000);
    wr(8'h55, '{8'h00});
    fifo_fill = 16'h0007;
    wr(8'h55, '{8'h04});
    rchk(8'h38, 2, 16'h0007);
    wr(8'h55, '{8'h00});
    pulse(0);
    fifo_fill = 16'h0014;
    wr(8'h55, '{8'h04});
    rchk(8'h38, 2, 16'h0007);
    wr(8'h55, '{8'h00});
    fifo_fill = 16'h0003;
    wr(8'h55, '{8'h04});
    rchk(8'h38, 2, 16'h0003);
    wr(8'h55, '{8'h00});
    $display("t_abort done");
  endtask

  task automatic t_standby();
    int r;
    int s;
    wr(8'h55, '{8'h10});
    chk(ctrl, 8'h10, "frame select");
    wr(8'h55, '{8'h41});
    chk({algo_pause_req, sensors_off}, 2'b10, "pause first");
    algo_pause_ready = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(sensors_off, 1'b1, "sensors down");
    r = n_rst;
    s = n_st;
    wr(8'h55, '{8'h40});
    chk({n_rst - r, n_st - s}, {32'd1, 32'd1}, "restart self-test");
    chk({algo_pause_req, sensors_off}, 2'b00, "resumed");
    algo_pause_ready = 1'b0;
    wr(8'h55, '{8'h01});
    wr(8'h55, '{8'h00});
    chk({n_rst - r, n_st - s}, {32'd2, 32'd1}, "no self-test");
    $display("t_standby done");
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    ev = '0;
    ack_value = 8'h00;
    fifo_fill = 16'h0000;
    algo_pause_ready = 1'b0;
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_reset();
    t_gp();
    t_param();
    t_irq();
    t_abort();
    t_standby();
    wrap_up();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    $display("FAIL %0t run did not finish", $time);
    wrap_up();
  end
endmodule
